// *** rtl/charger_smbus_pkg.sv ***
// Constants shared by the charger bus slave and its control logic.
// Assumes a 100 MHz system clock and a host-driven bus clock.
package charger_smbus_pkg;

	// System clock rate and the command watchdog
	localparam longint unsigned CLK_HZ = 100_000_000;
	localparam longint unsigned TIMEOUT_S = 175;
	localparam logic [34:0] TIMEOUT_CYCLES = 35'(TIMEOUT_S * CLK_HZ);

	// Bus address and command codes
	localparam logic [6:0] SLAVE_ADDR = 7'h09;
	localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
	localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
	localparam logic [7:0] CMD_INPUT_LIMIT = 8'h3F;
	localparam logic [7:0] CMD_DEVICE_IDENTITY_WORD = 8'hFE;
	localparam logic [7:0] CMD_MAKER_ID = 8'hFF;

	// Reset values of the settings
	localparam logic [15:0] RST_CHARGE_VOLTAGE = 16'h0000;
	localparam logic [15:0] RST_CHARGE_CURRENT = 16'h0000;
	localparam logic [15:0] RST_INPUT_LIMIT = 16'h0080;

	// Identity words; values are arbitrary
	localparam logic [15:0] DEVICE_IDENTITY_WORD_DEFAULT = 16'h5A31;
	localparam logic [15:0] MAKER_ID_DEFAULT = 16'h00C3;

	// Input limit field position and milliamp scaling
	localparam int LIMIT_LSB = 7;
	localparam int LIMIT_MSB = 12;
	localparam logic [13:0] LIMIT_MIN_MA = 14'h0100;
	localparam logic [13:0] LIMIT_MAX_MA = 14'h2AFC;

	// Bit counter value of the acknowledge clock
	localparam logic [3:0] BIT_ACK = 4'h8;

	typedef enum logic [2:0] {
		LINK_IDLE,
		LINK_ADDR,
		LINK_CMD,
		LINK_WLO,
		LINK_WHI,
		LINK_RLO,
		LINK_RHI,
		LINK_SKIP
	} link_state_t;

endpackage

// *** rtl/level_sync.sv ***
// Two flip-flop level synchroniser, one per bit of a vector.
// Assumes each bit is a level that stays put for several clocks.
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 1
) (
	// Clock and synchronous reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Asynchronous level in, synchronised level out
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] stage;

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			stage <= '0;
			q_out <= '0;
		end else begin
			stage <= d_in;
			q_out <= stage;
		end
	end

endmodule

// *** rtl/charger_smbus_control.sv ***
// Charger bus slave and charge-enable control.
// Assumes the host drives the bus clock, SDA is open drain with a pull-up,
// and the analog comparators arrive as asynchronous logic levels.
//
// Contract
// - Stop charging after 175 s without commands
// - After timeout, need both commands again
// - Input limit uses bits 7 to 12 only
// - Limit bits weigh 256 to 8192 mA
// - Adapter good released when detect input high
// - Settings kept while the interface supply holds
// - Charge only with adapter supply present
// - Zero voltage or current disables charging
// - Power fail blocks any charge attempt
// - Under reset hold settings, ignore bus (code reloads the reset values of the settings)
// - After reset wait for both commands
// - Charge only when all supply conditions hold
// - Answer only at seven-bit address 0x09
// - Never master, never start a transaction
// - Only word write and word read
// - Two read-only identity words at FE, FF
// - SDA changes only while SCL low
// - Bytes MSB first, sampled on SCL rise
// - Ninth clock carries the receiver acknowledge
// - Input limit written only at command 0x3F
// - Reset or small limit gives 256 mA
`timescale 1ns/1ps
module charger_smbus_control #(
	parameter logic [34:0] TIMEOUT_CYCLES = charger_smbus_pkg::TIMEOUT_CYCLES,
	parameter logic [15:0] DEVICE_IDENTITY_WORD = charger_smbus_pkg::DEVICE_IDENTITY_WORD_DEFAULT,
	parameter logic [15:0] MAKER_ID = charger_smbus_pkg::MAKER_ID_DEFAULT
) (
	// System clock and reset
	input wire logic clock_in,
	input wire logic nrst_in,
	// Bus pins
	input wire logic scl_clk_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Analog comparator levels
	input wire logic adapter_detect_input_in,
	input wire logic adapter_supply_input_ok_in,
	input wire logic gate_driver_supply_ok_in,
	input wire logic reference_ok_in,
	input wire logic sense_headroom_ok_in,
	input wire logic sense_power_fail_in,
	// Adapter good open-drain pin
	output logic adapter_good_output_out,
	output logic adapter_good_output_oe_out,
	// Settings and status
	output logic [15:0] charge_voltage_setting_out,
	output logic [15:0] charge_current_setting_out,
	output logic [15:0] input_limit_setting_out,
	output logic [13:0] input_limit_ma_out,
	output logic charge_enable_out,
	output logic timeout_out
);

	localparam logic [34:0] TIMER_LAST = TIMEOUT_CYCLES - 35'h0_0000_0001;

	// Bus clock domain
	logic scl_rst_n;
	charger_smbus_pkg::link_state_t state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shift, next_shift;
	logic [7:0] cmd, next_cmd;
	logic [7:0] data_lo, next_data_lo;
	logic [7:0] wr_cmd, next_wr_cmd;
	logic [15:0] wr_data, next_wr_data;
	logic wr_tog, next_wr_tog;
	logic start_seen, next_start_seen;
	logic sda_low, next_sda_low;
	logic [15:0] rd_word;
	logic [7:0] tx_byte;

	// System clock domain
	logic scl_s, sda_s, scl_p, sda_p;
	logic start_tog, next_start_tog;
	logic [5:0] analog_s;
	logic wr_tog_s, wr_tog_p;
	logic wr_pulse;
	logic [15:0] charge_voltage, next_charge_voltage;
	logic [15:0] charge_current, next_charge_current;
	logic [15:0] input_limit, next_input_limit;
	logic voltage_seen, next_voltage_seen;
	logic current_seen, next_current_seen;
	logic [34:0] timer, next_timer;
	logic timed_out, next_timed_out;
	logic charge_enable, next_charge_enable;
	logic [13:0] limit_ma, next_limit_ma;
	logic adapter_low, next_adapter_low;
	logic [5:0] limit_field;
	logic [13:0] limit_raw;
	logic supplies_ok;

	// Bus-side reset follows nrst_in over two bus clocks
	level_sync #(.WIDTH(1)) u_scl_rst (
		.clk_in(scl_clk_in),
		.nrst_in(1'b1),
		.d_in(nrst_in),
		.q_out(scl_rst_n)
	);

	always_comb begin
		unique case (cmd)
			charger_smbus_pkg::CMD_DEVICE_IDENTITY_WORD: rd_word = DEVICE_IDENTITY_WORD;
			charger_smbus_pkg::CMD_MAKER_ID: rd_word = MAKER_ID;
			default: rd_word = 16'h0000;
		endcase
		tx_byte = (state == charger_smbus_pkg::LINK_RHI) ?
			rd_word[15:8] : rd_word[7:0];
	end

	// Byte engine, sampled on the rising bus clock
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shift = shift;
		next_cmd = cmd;
		next_data_lo = data_lo;
		next_wr_cmd = wr_cmd;
		next_wr_data = wr_data;
		next_wr_tog = wr_tog;
		next_start_seen = start_seen;
		if (start_tog != start_seen) begin
			next_start_seen = start_tog;
			next_shift = {7'h00, sda_in};
			next_bit_cnt = 4'h1;
			next_state = charger_smbus_pkg::LINK_ADDR;
		end else begin
			unique case (state)
				charger_smbus_pkg::LINK_IDLE,
				charger_smbus_pkg::LINK_SKIP: begin
					next_bit_cnt = 4'h0;
				end
				charger_smbus_pkg::LINK_ADDR,
				charger_smbus_pkg::LINK_CMD,
				charger_smbus_pkg::LINK_WLO,
				charger_smbus_pkg::LINK_WHI: begin
					if (bit_cnt != charger_smbus_pkg::BIT_ACK) begin
						next_shift = {shift[6:0], sda_in};
						next_bit_cnt = bit_cnt + 4'h1;
					end else begin
						next_bit_cnt = 4'h0;
						unique case (state)
							charger_smbus_pkg::LINK_ADDR: begin
								if (shift[7:1] != charger_smbus_pkg::SLAVE_ADDR)
									next_state = charger_smbus_pkg::LINK_SKIP;
								else if (shift[0])
									next_state = charger_smbus_pkg::LINK_RLO;
								else
									next_state = charger_smbus_pkg::LINK_CMD;
							end
							charger_smbus_pkg::LINK_CMD: begin
								next_cmd = shift;
								next_state = charger_smbus_pkg::LINK_WLO;
							end
							charger_smbus_pkg::LINK_WLO: begin
								next_data_lo = shift;
								next_state = charger_smbus_pkg::LINK_WHI;
							end
							default: begin
								// Whole word only; partial writes never commit
								next_wr_cmd = cmd;
								next_wr_data = {shift, data_lo};
								next_wr_tog = ~wr_tog;
								next_state = charger_smbus_pkg::LINK_SKIP;
							end
						endcase
					end
				end
				charger_smbus_pkg::LINK_RLO,
				charger_smbus_pkg::LINK_RHI: begin
					if (bit_cnt != charger_smbus_pkg::BIT_ACK) begin
						next_bit_cnt = bit_cnt + 4'h1;
					end else begin
						next_bit_cnt = 4'h0;
						if (!sda_in && state == charger_smbus_pkg::LINK_RLO)
							next_state = charger_smbus_pkg::LINK_RHI;
						else
							next_state = charger_smbus_pkg::LINK_SKIP;
					end
				end
			endcase
		end
	end

	always_ff @(posedge scl_clk_in) begin
		// Bus side held idle in reset
		if (!scl_rst_n) begin
			state <= charger_smbus_pkg::LINK_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			cmd <= 8'h00;
			data_lo <= 8'h00;
			wr_cmd <= 8'h00;
			wr_data <= 16'h0000;
			wr_tog <= 1'b0;
			start_seen <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
			cmd <= next_cmd;
			data_lo <= next_data_lo;
			wr_cmd <= next_wr_cmd;
			wr_data <= next_wr_data;
			wr_tog <= next_wr_tog;
			start_seen <= next_start_seen;
		end
	end

	// SDA drive decided from the state left by the last rising edge
	always_comb begin
		next_sda_low = 1'b0;
		unique case (state)
			charger_smbus_pkg::LINK_ADDR: begin
				next_sda_low = (bit_cnt == charger_smbus_pkg::BIT_ACK) &&
					(shift[7:1] == charger_smbus_pkg::SLAVE_ADDR);
			end
			charger_smbus_pkg::LINK_CMD,
			charger_smbus_pkg::LINK_WLO,
			charger_smbus_pkg::LINK_WHI: begin
				next_sda_low = (bit_cnt == charger_smbus_pkg::BIT_ACK);
			end
			charger_smbus_pkg::LINK_RLO,
			charger_smbus_pkg::LINK_RHI: begin
				next_sda_low = (bit_cnt != charger_smbus_pkg::BIT_ACK) &&
					!tx_byte[3'h7 - bit_cnt[2:0]];
			end
			charger_smbus_pkg::LINK_IDLE,
			charger_smbus_pkg::LINK_SKIP: begin
				next_sda_low = 1'b0;
			end
		endcase
	end

	// SDA only changes on the falling bus clock
	always_ff @(negedge scl_clk_in) begin
		if (!scl_rst_n)
			sda_low <= 1'b0;
		else
			sda_low <= next_sda_low;
	end

	// Pin only ever pulled low, never a START
	assign sda_out = 1'b0;
	assign sda_oe_out = sda_low;

	// Pin and comparator synchronisers
	level_sync #(.WIDTH(2)) u_pin_sync (
		.clk_in(clock_in),
		.nrst_in(nrst_in),
		.d_in({scl_clk_in, sda_in}),
		.q_out({scl_s, sda_s})
	);

	level_sync #(.WIDTH(6)) u_analog_sync (
		.clk_in(clock_in),
		.nrst_in(nrst_in),
		.d_in({adapter_detect_input_in, adapter_supply_input_ok_in,
			gate_driver_supply_ok_in, reference_ok_in,
			sense_headroom_ok_in, sense_power_fail_in}),
		.q_out(analog_s)
	);

	level_sync #(.WIDTH(1)) u_wr_sync (
		.clk_in(clock_in),
		.nrst_in(nrst_in),
		.d_in(wr_tog),
		.q_out(wr_tog_s)
	);

	// Write data is held in the bus domain until the next word completes,
	// so it is stable long before the toggle arrives here.
	assign wr_pulse = wr_tog_s ^ wr_tog_p;

	localparam int LIMIT_MSB_I = charger_smbus_pkg::LIMIT_MSB;
	localparam int LIMIT_LSB_I = charger_smbus_pkg::LIMIT_LSB;
	assign limit_field = input_limit[LIMIT_MSB_I:LIMIT_LSB_I];
	// Binary weights of 256 mA per step
	assign limit_raw = {limit_field, 8'h00};

	assign supplies_ok = analog_s[4] && analog_s[3] && analog_s[2] &&
		analog_s[1];

	always_comb begin
		next_start_tog = start_tog;
		next_charge_voltage = charge_voltage;
		next_charge_current = charge_current;
		next_input_limit = input_limit;
		next_voltage_seen = voltage_seen;
		next_current_seen = current_seen;
		next_timer = timer;
		next_timed_out = timed_out;
		// START seen here; the bus side reads the toggle directly, since
		// it settles during the START hold, before the first rising clock.
		if (scl_s && scl_p && sda_p && !sda_s)
			next_start_tog = ~start_tog;
		if (voltage_seen || current_seen)
			next_timer = 35'(timer + 35'h0_0000_0001);
		if (wr_pulse) begin
			unique case (wr_cmd)
				charger_smbus_pkg::CMD_CHARGE_VOLTAGE: begin
					next_charge_voltage = wr_data;
					next_voltage_seen = 1'b1;
					next_timer = 35'h0_0000_0000;
				end
				charger_smbus_pkg::CMD_CHARGE_CURRENT: begin
					next_charge_current = wr_data;
					next_current_seen = 1'b1;
					next_timer = 35'h0_0000_0000;
				end
				charger_smbus_pkg::CMD_INPUT_LIMIT: begin
					next_input_limit = wr_data;
				end
				default: begin
					next_input_limit = input_limit;
				end
			endcase
		end else if ((voltage_seen || current_seen) && timer == TIMER_LAST) begin
			next_voltage_seen = 1'b0;
			next_current_seen = 1'b0;
			next_timer = 35'h0_0000_0000;
			next_timed_out = 1'b1;
		end
		if (next_voltage_seen && next_current_seen)
			next_timed_out = 1'b0;
		next_charge_enable = voltage_seen && current_seen &&
			(charge_voltage != 16'h0000) && (charge_current != 16'h0000) &&
			supplies_ok && !analog_s[0];
		// Floor and ceiling of the limit
		if (limit_field == 6'h00)
			next_limit_ma = charger_smbus_pkg::LIMIT_MIN_MA;
		else if (limit_raw > charger_smbus_pkg::LIMIT_MAX_MA)
			next_limit_ma = charger_smbus_pkg::LIMIT_MAX_MA;
		else
			next_limit_ma = limit_raw;
		next_adapter_low = !analog_s[5];
	end

	always_ff @(posedge clock_in) begin
		if (!nrst_in) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			wr_tog_p <= 1'b0;
			start_tog <= 1'b0;
			charge_voltage <= charger_smbus_pkg::RST_CHARGE_VOLTAGE;
			charge_current <= charger_smbus_pkg::RST_CHARGE_CURRENT;
			input_limit <= charger_smbus_pkg::RST_INPUT_LIMIT;
			voltage_seen <= 1'b0;
			current_seen <= 1'b0;
			timer <= 35'h0_0000_0000;
			timed_out <= 1'b0;
			charge_enable <= 1'b0;
			limit_ma <= charger_smbus_pkg::LIMIT_MIN_MA;
			adapter_low <= 1'b1;
		end else begin
			scl_p <= scl_s;
			sda_p <= sda_s;
			wr_tog_p <= wr_tog_s;
			start_tog <= next_start_tog;
			charge_voltage <= next_charge_voltage;
			charge_current <= next_charge_current;
			input_limit <= next_input_limit;
			voltage_seen <= next_voltage_seen;
			current_seen <= next_current_seen;
			timer <= next_timer;
			timed_out <= next_timed_out;
			charge_enable <= next_charge_enable;
			limit_ma <= next_limit_ma;
			adapter_low <= next_adapter_low;
		end
	end

	assign adapter_good_output_out = 1'b0;
	assign adapter_good_output_oe_out = adapter_low;
	assign charge_voltage_setting_out = charge_voltage;
	assign charge_current_setting_out = charge_current;
	assign input_limit_setting_out = input_limit;
	assign input_limit_ma_out = limit_ma;
	assign charge_enable_out = charge_enable;
	assign timeout_out = timed_out;

endmodule

// *** verification/charger_smbus_control_checker.sv ***
// Assertions on the charger slave's pins and status outputs.
// Bound to the top module; comparator inputs are async levels.
`timescale 1ns/1ps
module charger_smbus_control_checker (
	// Clock, reset and bus
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic scl_clk_in,
	input wire logic sda_oe_out,
	// Comparator levels
	input wire logic adapter_detect_input_in,
	input wire logic adapter_supply_input_ok_in,
	input wire logic gate_driver_supply_ok_in,
	input wire logic reference_ok_in,
	input wire logic sense_headroom_ok_in,
	input wire logic sense_power_fail_in,
	// Status
	input wire logic adapter_good_output_oe_out,
	input wire logic [15:0] charge_voltage_setting_out,
	input wire logic [15:0] charge_current_setting_out,
	input wire logic [15:0] input_limit_setting_out,
	input wire logic [13:0] input_limit_ma_out,
	input wire logic charge_enable_out,
	input wire logic timeout_out
);
	logic [5:0] field;
	logic [13:0] want_ma;
	logic rails_ok;
	assign field = input_limit_setting_out[12:7];
	assign want_ma = (field == 6'h00) ? 14'h0100 :
		({field, 8'h00} > 14'h2AFC) ? 14'h2AFC : {field, 8'h00};
	assign rails_ok = gate_driver_supply_ok_in && reference_ok_in &&
		sense_headroom_ok_in;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	// Levels pass two sync stages and a register
	sequence s_det_hi; adapter_detect_input_in [*5]; endsequence
	sequence s_det_lo; (!adapter_detect_input_in) [*5]; endsequence
	sequence s_scl_hi; scl_clk_in && $past(scl_clk_in); endsequence
	property p_sda_hold; s_scl_hi |-> $stable(sda_oe_out); endproperty
	property p_ag_rel; s_det_hi |-> !adapter_good_output_oe_out; endproperty
	property p_ag_pull; s_det_lo |-> adapter_good_output_oe_out; endproperty
	property p_no_supply;
		(!adapter_supply_input_ok_in) [*4] |-> !charge_enable_out;
	endproperty
	property p_rails; (!rails_ok) [*4] |-> !charge_enable_out; endproperty
	property p_pfail; sense_power_fail_in [*4] |-> !charge_enable_out;
	endproperty
	property p_zero; (charge_voltage_setting_out == 16'h0000 ||
		charge_current_setting_out == 16'h0000) |=> !charge_enable_out;
	endproperty
	property p_limit; $stable(input_limit_setting_out) [*3] |->
		input_limit_ma_out == want_ma;
	endproperty
	property p_tmo; timeout_out |=> !charge_enable_out; endproperty
	a_sda_hold: assert property (p_sda_hold)
		else $error("data enable moved while clock high");
	a_ag_rel: assert property (p_ag_rel)
		else $error("adapter good not released");
	a_ag_pull: assert property (p_ag_pull)
		else $error("adapter good not pulled low");
	a_no_supply: assert property (p_no_supply)
		else $error("charging without adapter supply");
	a_rails: assert property (p_rails)
		else $error("charging with a rail down");
	a_pfail: assert property (p_pfail)
		else $error("charging in power fail");
	a_zero: assert property (p_zero)
		else $error("charging with a zero setting");
	a_limit: assert property (p_limit)
		else $error("input limit milliamps wrong");
	a_tmo: assert property (p_tmo)
		else $error("charging after watchdog expiry");
endmodule
bind charger_smbus_control charger_smbus_control_checker u_checker (
	.clock_in(clock_in),
	.nrst_in(nrst_in),
	.scl_clk_in(scl_clk_in),
	.sda_oe_out(sda_oe_out),
	.adapter_detect_input_in(adapter_detect_input_in),
	.adapter_supply_input_ok_in(adapter_supply_input_ok_in),
	.gate_driver_supply_ok_in(gate_driver_supply_ok_in),
	.reference_ok_in(reference_ok_in),
	.sense_headroom_ok_in(sense_headroom_ok_in),
	.sense_power_fail_in(sense_power_fail_in),
	.adapter_good_output_oe_out(adapter_good_output_oe_out),
	.charge_voltage_setting_out(charge_voltage_setting_out),
	.charge_current_setting_out(charge_current_setting_out),
	.input_limit_setting_out(input_limit_setting_out),
	.input_limit_ma_out(input_limit_ma_out),
	.charge_enable_out(charge_enable_out),
	.timeout_out(timeout_out)
);

// *** verification/smbus_host_model.sv ***
// Behavioural bus host: framed word writes and word reads.
// Assumes the bench resolves SDA from both pull-downs and a pull-up.
`timescale 1ns/1ps
module smbus_host_model (
	// Resolved data wire
	input wire logic sda_in,
	// Host pins; clock idles high between frames
	output logic scl_out,
	output logic sda_pull_out
);
	initial begin
		scl_out = 1'b1;
		sda_pull_out = 1'b0;
	end
	// Idle clock bursts, only while the slave's bus side is in reset
	task automatic pulse(input int n);
		repeat (n) begin
			#43 scl_out = 1'b0;
			#40 scl_out = 1'b1;
		end
	endtask
	task automatic start();
		#23 sda_pull_out = 1'b0;
		#20 scl_out = 1'b1;
		#40 sda_pull_out = 1'b1;
		#120 scl_out = 1'b0;
	endtask
	task automatic stop();
		#20 sda_pull_out = 1'b1;
		#20 scl_out = 1'b1;
		#40 sda_pull_out = 1'b0;
		#40;
	endtask
	// byte MSB first, then acknowledge bit
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			#20 sda_pull_out = !d[i];
			#20 scl_out = 1'b1;
			#20 q[i] = sda_in;
			#20 scl_out = 1'b0;
		end
	endtask
	task automatic write_word(input logic [6:0] a, input logic [7:0] c,
		input logic [15:0] w, output logic ok);
		logic [8:0] q0, q1, q2, q3;
		start();
		xfer({a, 2'b01}, q0);
		xfer({c, 1'b1}, q1);
		xfer({w[7:0], 1'b1}, q2);
		xfer({w[15:8], 1'b1}, q3);
		stop();
		ok = !(q0[0] | q1[0] | q2[0] | q3[0]);
	endtask
	// word read: ack low byte, nack high byte
	task automatic read_word(input logic [7:0] c, output logic [15:0] w,
		output logic ok);
		logic [8:0] q0, q1, q2, q3, q4;
		start();
		xfer({charger_smbus_pkg::SLAVE_ADDR, 2'b01}, q0);
		xfer({c, 1'b1}, q1);
		start();
		xfer({charger_smbus_pkg::SLAVE_ADDR, 2'b11}, q2);
		xfer(9'h1FE, q3);
		xfer(9'h1FF, q4);
		stop();
		w = {q4[8:1], q3[8:1]};
		ok = !(q0[0] | q1[0] | q2[0]);
	endtask
endmodule

// *** verification/charger_smbus_control_tb.sv ***
// Bench for the charger slave: host model on the bus, levels here.
// Assumes the checker is bound and the host model compiled first.
`timescale 1ns/1ps
module charger_smbus_control_tb;
	localparam logic [34:0] TO_CYC = 35'h0_0000_07D0;
	localparam logic [6:0] ADR = 7'h09;
	logic clock_in = 1'b0;
	logic nrst_in = 1'b0;
	logic det = 1'b0;
	logic sup = 1'b1;
	logic pf = 1'b0;
	logic [2:0] rails = 3'h7;
	logic sda_out, sda_oe, ag, ag_oe, en, tmo, ok;
	logic [15:0] v, c, l, rd;
	logic [13:0] ma;
	wire logic scl, pull, sda_w, ag_pin;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [15:0] lim_in [6] = '{16'h0000, 16'h007F, 16'hE100,
		16'h0F80, 16'h1000, 16'h1F80};
	logic [13:0] lim_ma [6] = '{14'h0100, 14'h0100, 14'h0200,
		14'h1F00, 14'h2000, 14'h2AFC};
	assign sda_w = !pull && !(sda_oe && !sda_out);
	assign ag_pin = ag_oe ? ag : 1'b1;
	charger_smbus_control #(.TIMEOUT_CYCLES(TO_CYC)) DUT (
		.clock_in(clock_in), .nrst_in(nrst_in),
		.scl_clk_in(scl), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe_out(sda_oe),
		.adapter_detect_input_in(det),
		.adapter_supply_input_ok_in(sup),
		.gate_driver_supply_ok_in(rails[0]),
		.reference_ok_in(rails[1]),
		.sense_headroom_ok_in(rails[2]),
		.sense_power_fail_in(pf),
		.adapter_good_output_out(ag),
		.adapter_good_output_oe_out(ag_oe),
		.charge_voltage_setting_out(v),
		.charge_current_setting_out(c),
		.input_limit_setting_out(l),
		.input_limit_ma_out(ma),
		.charge_enable_out(en),
		.timeout_out(tmo)
	);
	smbus_host_model host (
		.sda_in(sda_w), .scl_out(scl), .sda_pull_out(pull)
	);
	initial begin
		forever #5 clock_in = ~clock_in;
	end
	// Hang guard, well above the expected run length
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			$display("Error %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clock_in);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] cm,
		input logic [15:0] d, input logic ea);
		host.write_word(a, cm, d, ok);
		wt(8);
		chk("ack", {15'h0000, ea}, {15'h0000, ok});
	endtask
	task automatic rdc(input logic [7:0] cm, input logic [15:0] e);
		host.read_word(cm, rd, ok);
		wt(2);
		chk("read word", e, rd);
	endtask
	task automatic chk_en(input logic e);
		chk("enable", {15'h0000, e}, {15'h0000, en});
	endtask
	task conclude();
		$display("Errors %0d checks %0d", err_total, n_checks);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		fork
			wt(20);
			host.pulse(3);
		join
		@(posedge clock_in);
		nrst_in <= 1'b1;
		// Bus side leaves reset only after two bus clock rises
		host.pulse(2);
		@(posedge clock_in);
		chk("por settings", 16'h0000, v | c);
		chk("por limit", 16'h0080, l);
		chk("por ma", 16'h0100, {2'b00, ma});
		chk("por flags", 16'h0000, {14'h0000, en, tmo});
		wt(4);
		chk("adapter pin", 16'h0000, {15'h0000, ag_pin});
		det <= 1'b1;
		wt(6);
		chk("adapter pin", 16'h0001, {15'h0000, ag_pin});
		rdc(8'hFE, charger_smbus_pkg::DEVICE_IDENTITY_WORD_DEFAULT);
		rdc(8'hFF, charger_smbus_pkg::MAKER_ID_DEFAULT);
		wr(ADR, 8'hFE, 16'h1234, 1'b1);
		wr(ADR, 8'h20, 16'hFFFF, 1'b1);
		wr(7'h49, 8'h15, 16'h1111, 1'b0);
		rdc(8'hFE, charger_smbus_pkg::DEVICE_IDENTITY_WORD_DEFAULT);
		chk("settings", 16'h0000, v | c);
		chk("limit", 16'h0080, l);
		for (int i = 0; i < 6; i++) begin
			wr(ADR, 8'h3F, lim_in[i], 1'b1);
			chk("limit word", lim_in[i], l);
			chk("limit ma", {2'b00, lim_ma[i]}, {2'b00, ma});
		end
		wr(ADR, 8'h15, 16'h3000, 1'b1);
		chk_en(1'b0);
		wr(ADR, 8'h14, 16'h0400, 1'b1);
		chk("voltage", 16'h3000, v);
		chk_en(1'b1);
		for (int i = 0; i < 3; i++) begin
			rails <= ~(3'h1 << i);
			wt(6);
			chk_en(1'b0);
			rails <= 3'h7;
			wt(6);
			chk_en(1'b1);
		end
		sup <= 1'b0;
		wt(6);
		chk_en(1'b0);
		chk("voltage kept", 16'h3000, v);
		sup <= 1'b1;
		pf <= 1'b1;
		wt(6);
		chk_en(1'b0);
		pf <= 1'b0;
		wr(ADR, 8'h14, 16'h0000, 1'b1);
		chk_en(1'b0);
		wr(ADR, 8'h14, 16'h0400, 1'b1);
		chk_en(1'b1);
		wt(1500);
		wr(ADR, 8'h15, 16'h3000, 1'b1);
		wt(1500);
		chk("timeout", 16'h0000, {15'h0000, tmo});
		chk_en(1'b1);
		wt(2100);
		chk("timeout", 16'h0001, {15'h0000, tmo});
		chk_en(1'b0);
		wr(ADR, 8'h15, 16'h3000, 1'b1);
		chk_en(1'b0);
		wr(ADR, 8'h14, 16'h0400, 1'b1);
		chk_en(1'b1);
		chk("timeout", 16'h0000, {15'h0000, tmo});
		nrst_in <= 1'b0;
		wt(4);
		host.write_word(ADR, 8'h15, 16'h5555, ok);
		wt(2);
		chk("reset ack", 16'h0000, {15'h0000, ok});
		chk("reset voltage", 16'h0000, v);
		nrst_in <= 1'b1;
		wt(2);
		chk("reset limit", 16'h0080, l);
		conclude();
	end
endmodule
